// ==== src/dcsp_shared_port.sv ====
// Shared eight-pin port: LED display scan, processor register access, configuration load.
// Assumes an external transceiver steered by the buffer enable and latches fed by the strobe.
`timescale 1ns/100ps
// Notes on behaviour
// - Display scan pulses the latch strobe low once per port slot.
// - Latch strobe stays high while a processor strobe is asserted.
// - During display scan all eight pins drive address and display data.
// - In an access, upper nibble is address in, lower nibble is data.
// - Pins stay in display mode except while a processor strobe is asserted or load/reset is low.
// - After a transmitted packet, pulse frozen strobe; hold status until receive or 30 ms.
// - Buffer enable is high in display scan, low in access or load.
// - Buffer enable steers the external transceiver between pins and processor bus.
// - Write strobe stores the low two bits of the lower nibble into the addressed port register.
// - Read strobe drives the addressed register onto the lower nibble.
// - While load/reset is low, hold all state machines and ports reset.
// - Rising edge of load/reset latches all eight pins into configuration.
// - Rising edge of load/reset starts the display test.
// - All timing derives from the single system clock.
// - Each port has a status register readable, and writable for disable and squelch.
module dcsp_shared_port
    import dcsp_pkg::*;
#(
    parameter int NPORT      = dcsp_pkg::PORT_COUNT,
    parameter int FREEZE_CYC = dcsp_pkg::FREEZE_CYCLES,
    parameter int DIV        = dcsp_pkg::DISP_DIV,
    parameter int TEST_N     = dcsp_pkg::TEST_SCANS
) (
    // Clock and reset.
    input  wire logic                     clk_sys,
    input  wire logic                     reset_n,
    // Processor strobes, load/reset and shared data pins.
    input  wire dcsp_pkg::dcsp_pins_t     pinIn,
    output dcsp_pkg::dcsp_drive_t         dataDrive_q,
    output logic                          displayLatchStrobe_n_q,
    output logic                          displayFrozenPulse_q,
    output logic                          dataBufferEnable_q,
    // Repeater core events and per-port live status.
    input  wire logic                     txPacketEnd,
    input  wire logic                     rxPacketStart,
    input  wire logic [NPORT-1:0][3:0]    portLiveStatus,
    // Configuration and port control towards the repeater core.
    output logic      [7:0]               configReg_q,
    output logic                          coreHold_q,
    output logic                          displayTest_q,
    output logic      [NPORT-1:0][1:0]    portCtrl_q
);
    import dcsp_pkg::*;

    localparam int FW = $clog2(FREEZE_CYC + 1);
    localparam int DW = $clog2(DIV + 1);
    localparam int TW = $clog2(TEST_N * NPORT + 1);

    dcsp_pins_t           pinLvl;
    dcsp_state_t          state_q;
    logic                 readReq;
    logic                 writeReq;
    logic                 loadLvlOld_q;
    logic                 loadRise;
    logic [3:0]           accAddr_q;
    logic [3:0]           accData_q;
    logic                 accWrite_q;
    logic [DW-1:0]        divCnt_q;
    logic                 slotTick;
    logic [3:0]           scanAddr_q;
    logic                 strobePend_q;
    logic                 frozen_q;
    logic [FW-1:0]        freezeCnt_q;
    logic [NPORT-1:0][3:0] snap_q;
    logic [TW-1:0]        testCnt_q;
    logic [3:0]           dispNibble;

    // Address nibble to port slot; slot numbers start at one.
    function automatic logic portOk(input logic [3:0] addr);
        portOk = (addr != ZERO_NIBBLE) && (32'(addr) <= NPORT);
    endfunction

    function automatic logic [3:0] portSlot(input logic [3:0] addr);
        portSlot = addr - 4'h1;
    endfunction

    // Strobes and data are asynchronous pins and take the three-stage path.
    dcsp_pin_sync #(
        .W         ($bits(dcsp_pins_t)),
        .RESET_VAL ({1'b1, 1'b1, 1'b1, 8'h00})
    ) u_sync (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .pinRaw     (pinIn),
        .pinLevel_q (pinLvl)
    );

    assign readReq  = !pinLvl.readStrobe_n;
    assign writeReq = !pinLvl.writeStrobe_n;
    assign loadRise = pinLvl.configLoadReset_n && !loadLvlOld_q;

    // slot divider
    // The scan rate is an enable pulse from the one system clock.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            divCnt_q <= '0;
        end else if (divCnt_q == DW'(DIV - 1)) begin
            divCnt_q <= '0;
        end else begin
            divCnt_q <= divCnt_q + DW'(1);
        end
    end
    assign slotTick = (divCnt_q == DW'(DIV - 1));

    // Load level history for edge detection on the accepted level.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            loadLvlOld_q <= 1'b1;
        end else begin
            loadLvlOld_q <= pinLvl.configLoadReset_n;
        end
    end

    // Display content: test pattern, frozen snapshot, or live status.
    always_comb begin
        dispNibble = ZERO_NIBBLE;
        if (testCnt_q != '0) begin
            dispNibble = TEST_NIBBLE;
        end else if (portOk(scanAddr_q)) begin
            dispNibble = frozen_q ? snap_q[portSlot(scanAddr_q)] : portLiveStatus[portSlot(scanAddr_q)];
        end
    end

    // Pin ownership state and the registered pin outputs it steers.
    // Load beats access, access beats display; leaving display releases the pins first.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q                <= ST_LOAD;
            dataDrive_q            <= '0;
            dataBufferEnable_q     <= 1'b0;
            displayLatchStrobe_n_q <= 1'b1;
            strobePend_q           <= 1'b0;
            scanAddr_q             <= 4'h1;
            coreHold_q             <= 1'b1;
        end else if (!pinLvl.configLoadReset_n) begin
            state_q                <= ST_LOAD;
            coreHold_q             <= 1'b1;
            dataDrive_q.oe         <= OE_NONE;
            dataBufferEnable_q     <= 1'b0;
            displayLatchStrobe_n_q <= 1'b1;
            strobePend_q           <= 1'b0;
        end else begin
            coreHold_q <= 1'b0;
            case (state_q)
                ST_LOAD: begin
                    state_q    <= ST_DISPLAY;
                    scanAddr_q <= 4'h1;
                end
                ST_DISPLAY: begin
                    if (readReq || writeReq) begin
                        displayLatchStrobe_n_q <= 1'b1;
                        strobePend_q           <= 1'b0;
                        dataBufferEnable_q     <= 1'b0;
                        dataDrive_q.oe         <= OE_NONE;
                        state_q                <= ST_RELEASE;
                    end else begin
                        dataDrive_q.oe     <= OE_ALL;
                        dataBufferEnable_q <= 1'b1;
                        if (slotTick) begin
                            dataDrive_q.out <= {scanAddr_q, dispNibble};
                            strobePend_q    <= 1'b1;
                            scanAddr_q      <= (32'(scanAddr_q) >= NPORT) ? 4'h1 : scanAddr_q + 4'h1;
                        end else begin
                            strobePend_q <= 1'b0;
                        end
                        displayLatchStrobe_n_q <= !strobePend_q;
                    end
                end
                ST_RELEASE: begin
                    state_q <= (readReq || writeReq) ? ST_ACCESS : ST_DISPLAY;
                end
                ST_ACCESS: begin
                    if (readReq) begin
                        dataDrive_q.oe  <= OE_LOW_NIBBLE;
                        dataDrive_q.out <= {ZERO_NIBBLE, portOk(accAddr_q) ?
                            {portLiveStatus[portSlot(accAddr_q)][3:LIVE_LSB], portCtrl_q[portSlot(accAddr_q)]} :
                            ZERO_NIBBLE};
                    end else begin
                        dataDrive_q.oe <= OE_NONE;
                    end
                    if (!readReq && !writeReq) begin
                        state_q <= ST_DISPLAY;
                    end
                end
                default: begin
                    state_q <= ST_DISPLAY;
                end
            endcase
        end
    end

    // address in upper nibble
    // Address and write data follow the pins while the strobe is held.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            accAddr_q  <= ZERO_NIBBLE;
            accData_q  <= ZERO_NIBBLE;
            accWrite_q <= 1'b0;
        end else if (state_q == ST_ACCESS && (readReq || writeReq)) begin
            accAddr_q  <= pinLvl.data[7:4];
            accData_q  <= pinLvl.data[3:0];
            accWrite_q <= writeReq;
        end else if (state_q != ST_ACCESS) begin
            accWrite_q <= 1'b0;
        end
    end

    // port control bits
    // The low two bits of the nibble are committed as the strobe ends, so the value last seen on the pins counts.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            portCtrl_q <= '0;
        end else if (!pinLvl.configLoadReset_n) begin
            portCtrl_q <= '0;
        end else if (state_q == ST_ACCESS && accWrite_q && !writeReq && portOk(accAddr_q)) begin
            portCtrl_q[portSlot(accAddr_q)] <= accData_q[CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            configReg_q   <= CONFIG_RESET;
            testCnt_q     <= '0;
            displayTest_q <= 1'b0;
        end else begin
            if (loadRise) begin
                configReg_q <= pinLvl.data;
                testCnt_q   <= TW'(TEST_N * NPORT);
            end else if (testCnt_q != '0 && slotTick && state_q == ST_DISPLAY) begin
                testCnt_q <= testCnt_q - TW'(1);
            end
            displayTest_q <= loadRise || (testCnt_q > TW'(1)) || (testCnt_q == TW'(1) && !slotTick);
        end
    end

    // frozen display
    // A packet end in the same cycle as a receive start wins, so no freeze is lost.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            frozen_q             <= 1'b0;
            freezeCnt_q          <= '0;
            displayFrozenPulse_q <= 1'b0;
            snap_q               <= '0;
        end else begin
            displayFrozenPulse_q <= txPacketEnd && pinLvl.configLoadReset_n;
            if (!pinLvl.configLoadReset_n) begin
                frozen_q    <= 1'b0;
                freezeCnt_q <= '0;
            end else if (txPacketEnd) begin
                frozen_q    <= 1'b1;
                freezeCnt_q <= FW'(FREEZE_CYC - 1);
                snap_q      <= portLiveStatus;
            end else if (rxPacketStart || freezeCnt_q == '0) begin
                frozen_q    <= 1'b0;
                freezeCnt_q <= '0;
            end else begin
                freezeCnt_q <= freezeCnt_q - FW'(1);
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_strobe_one_cycle: assert property (!displayLatchStrobe_n_q |=> displayLatchStrobe_n_q)
        else $error("Latch strobe held low longer than one cycle.");
    a_strobe_idle_acc: assert property ((readReq || writeReq) |=> displayLatchStrobe_n_q)
        else $error("Latch strobe active during processor access.");
    a_pins_drive_all: assert property (state_q == ST_DISPLAY && !readReq && !writeReq
        && pinLvl.configLoadReset_n |=> dataDrive_q.oe == OE_ALL)
        else $error("Pins not driven in display scan.");
    a_read_low_nibble: assert property (state_q == ST_ACCESS && readReq && pinLvl.configLoadReset_n
        |=> dataDrive_q.oe == OE_LOW_NIBBLE)
        else $error("Read did not drive the low nibble only.");
    a_data_buffer_enable_mode: assert property ((readReq || writeReq || !pinLvl.configLoadReset_n) |=> !dataBufferEnable_q)
        else $error("Buffer enable high during access or load.");
    a_release_first: assert property ($rose(state_q == ST_ACCESS) |-> $past(dataDrive_q.oe) == OE_NONE)
        else $error("Pins sampled without being released.");
    a_write_commit: assert property ((state_q == ST_ACCESS && accWrite_q && !writeReq && portOk(accAddr_q)
        && pinLvl.configLoadReset_n) |=> portCtrl_q[portSlot($past(accAddr_q))] == $past(accData_q[CTRL_W-1:0]))
        else $error("Write data not stored in port register.");
    a_load_hold: assert property (!pinLvl.configLoadReset_n |=> coreHold_q && dataDrive_q.oe == OE_NONE)
        else $error("Core not held during load.");
    a_load_latch: assert property (loadRise |=> configReg_q == $past(pinLvl.data) && displayTest_q)
        else $error("Configuration not latched on load edge.");
    a_freeze_pulse: assert property (txPacketEnd && pinLvl.configLoadReset_n |=> displayFrozenPulse_q
        && frozen_q ##1 (!displayFrozenPulse_q || $past(txPacketEnd)))
        else $error("Frozen strobe not pulsed after packet end.");
    a_freeze_bound: assert property (frozen_q |-> 32'(freezeCnt_q) < FREEZE_CYC)
        else $error("Freeze time exceeds its limit.");

    c_read_access: cover property (state_q == ST_ACCESS && readReq ##1 !readReq);
    c_write_commit: cover property (state_q == ST_ACCESS && accWrite_q && !writeReq);
    c_freeze_rx_end: cover property (frozen_q ##1 rxPacketStart ##1 !frozen_q);
    c_load_edge: cover property (loadRise);
endmodule

// ==== src/dcsp_pkg.sv ====
// Constants, types and states for the display and processor shared port.
// Assumes a single 25 MHz system clock; every pin input is asynchronous.
package dcsp_pkg;

    // Pin group widths and drive patterns.
    localparam int          DATA_W        = 8;
    localparam int          NIB_W         = 4;
    localparam int          PORT_COUNT    = 7;
    localparam logic [7:0]  OE_ALL        = 8'hff;
    localparam logic [7:0]  OE_LOW_NIBBLE = 8'h0f;
    localparam logic [7:0]  OE_NONE       = 8'h00;
    localparam logic [3:0]  TEST_NIBBLE   = 4'hf;
    localparam logic [3:0]  ZERO_NIBBLE   = 4'h0;
    localparam logic [7:0]  CONFIG_RESET  = 8'h00;

    // Per-port control bits held in the low half of a written nibble.
    localparam int          CTRL_W        = 2;
    localparam int          CTRL_DISABLE  = 0;
    localparam int          CTRL_SQUELCH  = 1;
    localparam int          LIVE_LSB      = 2;

    // Timing: clock rate and the longest frozen-display time.
    localparam int          CLK_HZ        = 25000000;
    localparam int          FREEZE_MS     = 30;
    localparam int          FREEZE_CYCLES = (CLK_HZ / 1000) * FREEZE_MS;
    localparam int          DISP_DIV      = 8;
    localparam int          TEST_SCANS    = 4;

    // Bundled pin inputs: three active low strobes and the data byte.
    typedef struct packed {
        logic       readStrobe_n;
        logic       writeStrobe_n;
        logic       configLoadReset_n;
        logic [7:0] data;
    } dcsp_pins_t;

    // Shared data pins as output value and per-bit enable.
    typedef struct packed {
        logic [7:0] oe;
        logic [7:0] out;
    } dcsp_drive_t;

    // Who owns the shared pins.
    typedef enum logic [2:0] {
        ST_DISPLAY = 3'b000,
        ST_RELEASE = 3'b001,
        ST_ACCESS  = 3'b010,
        ST_LOAD    = 3'b100
    } dcsp_state_t;

endpackage

// ==== src/dcsp_pin_sync.sv ====
// Three-stage synchroniser for a group of asynchronous pin inputs.
// A bit's accepted level changes only once stages two and three agree.
`timescale 1ns/100ps
module dcsp_pin_sync #(
    parameter int                 W         = 11,
    parameter logic [W-1:0]       RESET_VAL = '0
) (
    // Clock and reset.
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    // Raw pins and their filtered level.
    input  wire logic [W-1:0]     pinRaw,
    output logic      [W-1:0]     pinLevel_q
);
    logic [W-1:0] stage1_q;
    logic [W-1:0] stage2_q;
    logic [W-1:0] stage3_q;

    // Stage one feeds only stage two, so metastability never reaches logic.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stage1_q <= RESET_VAL;
            stage2_q <= RESET_VAL;
            stage3_q <= RESET_VAL;
        end else begin
            stage1_q <= pinRaw;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    // A bit that is still settling keeps its old accepted level.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pinLevel_q <= RESET_VAL;
        end else begin
            pinLevel_q <= (stage3_q & ~(stage2_q ^ stage3_q)) | (pinLevel_q & (stage2_q ^ stage3_q));
        end
    end
endmodule

// ==== testbench/dcsp_host_model.sv ====
// Host side model: processor bus transceiver, display latches and the shared pad wire.
// Assumes the bench steers the processor drive; the device drive comes from the port.
`timescale 1ns/100ps
module dcsp_host_model
    import dcsp_pkg::*;
(
    // Clock.
    input  wire logic                  clk_sys,
    // Device drive, strobe and transceiver enable.
    input  wire dcsp_pkg::dcsp_drive_t devDrive,
    input  wire logic                  latchStrobe_n,
    input  wire logic                  bufEnable,
    // Processor side drive from the bench.
    input  wire logic [7:0]            hostOe,
    input  wire logic [7:0]            hostData,
    // Resolved pads, latched display byte and contention flag.
    output logic      [7:0]            padLevel,
    output logic      [7:0]            latchByte,
    output logic                       contention
);
    logic [7:0] lastPad_q;
    logic [7:0] hostEff;

    // transceiver direction control
    // The transceiver passes processor drive only while the buffer enable is low.
    assign hostEff = bufEnable ? 8'h00 : hostOe;
    assign contention = |(hostEff & devDrive.oe);

    // processor pad drive
    // An undriven pad shows the inverse of its last level, so stale data never passes as valid.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            padLevel[i] = devDrive.oe[i] ? devDrive.out[i] : (hostEff[i] ? hostData[i] : ~lastPad_q[i]);
        end
    end

    // Remembers the pad level for the floating case.
    always_ff @(posedge clk_sys) begin
        lastPad_q <= padLevel;
    end

    // display latch capture
    // The external latch closes on the rising edge of the strobe.
    always_ff @(posedge latchStrobe_n) begin
        latchByte <= padLevel;
    end
endmodule

// ==== testbench/display_cpu_shared_port_tb.sv ====
// Self-checking bench for the shared display and processor port.
// Assumes the host model resolves the pads; the freeze time is shortened by parameter.
`timescale 1ns/100ps
module display_cpu_shared_port_tb;
    import dcsp_pkg::*;
    localparam int NP  = 7;
    localparam int FRZ = 400;

    logic               clk_sys = 1'b0;
    logic               reset_n = 1'b0;
    logic               rdStrobe_n, wrStrobe_n, load_n, txEnd, rxStart;
    dcsp_pins_t         pinIn;
    dcsp_drive_t        dataDrive_q;
    logic               strobe_n, frozen, data_buffer_enable, coreHold, dispTest, contention;
    logic [NP-1:0][3:0] live, old;
    logic [NP-1:0][1:0] portCtrl, ctrlExp;
    logic [7:0]         configReg, hostOe, hostData, padLevel, latchByte, cfg;
    logic [3:0]         got, addr, nib;
    logic               rd;
    int                 n_fail = 0;
    int                 checked = 0;
    int                 seed;

    assign pinIn = {rdStrobe_n, wrStrobe_n, load_n, padLevel};

    // Clock at 25 MHz.
    always #20 clk_sys = ~clk_sys;

    dcsp_shared_port #(.NPORT(NP), .FREEZE_CYC(FRZ), .DIV(8), .TEST_N(2)) uut (
        .clk_sys(clk_sys), .reset_n(reset_n), .pinIn(pinIn), .dataDrive_q(dataDrive_q),
        .displayLatchStrobe_n_q(strobe_n), .displayFrozenPulse_q(frozen), .dataBufferEnable_q(data_buffer_enable),
        .txPacketEnd(txEnd), .rxPacketStart(rxStart), .portLiveStatus(live), .configReg_q(configReg),
        .coreHold_q(coreHold), .displayTest_q(dispTest), .portCtrl_q(portCtrl));

    dcsp_host_model host (
        .clk_sys(clk_sys), .devDrive(dataDrive_q), .latchStrobe_n(strobe_n), .bufEnable(data_buffer_enable),
        .hostOe(hostOe), .hostData(hostData), .padLevel(padLevel), .latchByte(latchByte),
        .contention(contention));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (n_fail == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic timeout();
        n_fail++;
        $display("unexpected at %0t: wait limit reached", $time);
        summarize();
    endtask

    // Waits for one latch pulse, then lets the latch close.
    task automatic waitStrobe();
        for (int i = 0; i < 40 && strobe_n !== 1'b0; i++) @(negedge clk_sys);
        if (strobe_n !== 1'b0) timeout();
        @(negedge clk_sys);
    endtask

    // One full scan: addresses cycle and each slot shows the expected nibble.
    task automatic scanCheck(input logic [NP-1:0][3:0] view, input logic test);
        logic [3:0] prev;
        logic [3:0] a;
        prev = 4'h0;
        for (int k = 0; k < NP; k++) begin
            waitStrobe();
            a = latchByte[7:4];
            chk(16'(data_buffer_enable), 16'h1);
            chk(16'(dataDrive_q.oe), 16'(OE_ALL));
            if (k > 0) chk(16'(a), 16'((prev % NP) + 1));
            if (a >= 1 && a <= NP) chk(16'(latchByte[3:0]), test ? 16'(TEST_NIBBLE) : 16'(view[a-1]));
            else chk(16'(a), 16'h1);
            prev = a;
        end
    endtask

    // One processor cycle; the host keeps its drive two cycles past the strobe.
    task automatic access(input logic isRd, input logic [3:0] a, input logic [3:0] d, output logic [3:0] q);
        @(negedge clk_sys);
        hostOe = isRd ? 8'hf0 : 8'hff;
        hostData = {a, d};
        if (isRd) rdStrobe_n = 1'b0;
        else wrStrobe_n = 1'b0;
        for (int i = 0; i < 16; i++) begin
            @(negedge clk_sys);
            if (i >= 8) begin
                chk(16'(strobe_n), 16'h1);
                chk(16'(data_buffer_enable), 16'h0);
                chk(16'(dataDrive_q.oe[7:4]), 16'h0);
            end
        end
        chk(16'(dataDrive_q.oe), isRd ? 16'(OE_LOW_NIBBLE) : 16'(OE_NONE));
        q = padLevel[3:0];
        rdStrobe_n = 1'b1;
        wrStrobe_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        hostOe = 8'h00;
        for (int i = 0; i < 30 && dataDrive_q.oe !== OE_ALL; i++) @(negedge clk_sys);
        if (dataDrive_q.oe !== OE_ALL) timeout();
        chk(16'(dataDrive_q.oe), 16'(OE_ALL));
    endtask

    // No falling clock edge may see both parties driving a pad.
    always @(negedge clk_sys) begin
        if (reset_n) chk(16'(contention), 16'h0);
    end

    initial begin
        rdStrobe_n = 1'b1;
        wrStrobe_n = 1'b1;
        load_n = 1'b0;
        txEnd = 1'b0;
        rxStart = 1'b0;
        live = '0;
        hostOe = 8'h00;
        hostData = 8'h00;
        ctrlExp = '0;
        seed = $urandom(12);
        repeat (6) @(negedge clk_sys);
        reset_n = 1'b1;
        // Configuration load, twice, with the pins held across the rise.
        for (int n = 0; n < 2; n++) begin
            @(negedge clk_sys);
            load_n = 1'b0;
            cfg = 8'($urandom);
            hostOe = 8'hff;
            hostData = cfg;
            repeat (8) @(negedge clk_sys);
            chk(16'(coreHold), 16'h1);
            chk(16'(data_buffer_enable), 16'h0);
            load_n = 1'b1;
            repeat (6) @(negedge clk_sys);
            hostOe = 8'h00;
            repeat (2) @(negedge clk_sys);
            chk(16'(configReg), 16'(cfg));
            chk(16'(dispTest), 16'h1);
            chk(16'(coreHold), 16'h0);
        end
        scanCheck(live, 1'b1);
        for (int i = 0; i < 200 && dispTest !== 1'b0; i++) @(negedge clk_sys);
        if (dispTest !== 1'b0) timeout();
        live = 28'($urandom);
        waitStrobe();
        scanCheck(live, 1'b0);
        // Processor writes to every port, then random reads and writes, some unmapped.
        for (int k = 0; k < 24; k++) begin
            addr = (k < NP) ? 4'(k + 1) : 4'($urandom_range(0, 10));
            rd = (k >= NP) && ($urandom_range(0, 1) == 1);
            nib = 4'($urandom);
            access(rd, addr, nib, got);
            if (rd) chk(16'(got), (addr >= 1 && addr <= NP) ? 16'({live[addr-1][3:2], ctrlExp[addr-1]}) : 16'h0);
            else if (addr >= 1 && addr <= NP) ctrlExp[addr-1] = nib[1:0];
            chk(16'(portCtrl), 16'(ctrlExp));
        end
        // Freeze released by a received packet, then by the time limit.
        for (int m = 0; m < 2; m++) begin
            @(negedge clk_sys);
            txEnd = 1'b1;
            @(negedge clk_sys);
            txEnd = 1'b0;
            for (int i = 0; i < 4 && frozen !== 1'b1; i++) @(negedge clk_sys);
            if (frozen !== 1'b1) timeout();
            chk(16'(frozen), 16'h1);
            @(negedge clk_sys);
            chk(16'(frozen), 16'h0);
            old = live;
            live = 28'($urandom);
            scanCheck(old, 1'b0);
            if (m == 0) begin
                rxStart = 1'b1;
                @(negedge clk_sys);
                rxStart = 1'b0;
            end else begin
                repeat (FRZ) @(negedge clk_sys);
            end
            waitStrobe();
            scanCheck(live, 1'b0);
        end
        summarize();
    end
endmodule
